// >>> verilog/drive_status_word_generator.sv
// Module: builds the cyclic 16-bit drive status word from drive conditions
//
// How it works
// R01: In-window when actual speed lies within compare speed plus or minus width.
// R02: Speed mode bit 8 sets only after in-window held for response delay.
// R03: Leaving window clears bit 8 at once and restarts delay count.
// R04: Speed mode bit 10 set when actual speed reaches or exceeds threshold.
// R05: Bit 2 follows controller enabling.
// R06: Bit 4 high unless coast stop requested.
// R07: Bit 5 high unless quick stop requested.
// R08: Bit 7 set on warning or limit switch setpoint inhibit.
// R09: Positioning mode bit 8 set when no following error.
// R10: Bit 9 mirrors control word bit 10.
// R11: Positioning bit 10 set when run finished and inside target window.
// R12: Positioning bit 11 set after homing, cleared if invalid or not homed.
// R13: Absolute encoder reports home valid without homing.
// R14: Positioning bit 13 set when near zero speed, no positioning, no quick stop.
// R15: Bits 8, 10 to 13 change meaning with operating mode.
// R16: Masked by 0047h, inhibited reads 0040h, ready reads 0001h.
// R17: Masked by 0047h, switched on reads 0003h.
// R18: Master ignores bits 4 and 5 when decoding state.
// R19: Status word sits at a fixed telegram position for types 0 to 2.
// R20: Master waits for requested state before next command.
// R21: Unassigned bits 14 and 15 read zero.
`timescale 1ns/10ps

module drive_status_word_generator
  import status_word_pkg::*;
#(
  parameter logic [SPEED_W-1:0] STOP_BAND = STOP_BAND_DEF
) (
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire status_word_pkg::speed_cfg_t speed,
  input  wire status_word_pkg::pos_flags_t pos,
  input  wire status_word_pkg::drive_state_t drive_state,
  input  wire logic                    positioning_mode,
  input  wire logic [15:0]             control_word,
  input  wire logic                    controller_enabled,
  input  wire logic                    coast_stop_request,
  input  wire logic                    quick_stop_request,
  input  wire logic                    warning_active,
  input  wire logic                    limit_inhibit,
  output logic [15:0]                  drive_status_word
);
  import status_word_pkg::*;

  logic                 in_window;
  logic [DELAY_W-1:0]   delay_count;
  logic [DELAY_W-1:0]   next_delay_count;
  logic                 speed_ok;
  logic                 next_speed_ok;
  logic [15:0]          next_status;
  logic signed [SPEED_W:0] diff;
  logic                 near_zero;

  // Wide difference avoids overflow at speed extremes
  always_comb begin
    diff      = {speed.actual[SPEED_W-1], speed.actual} - {speed.compare[SPEED_W-1], speed.compare};
    in_window = (diff <= $signed({2'b00, speed.window[SPEED_W-2:0]}))
             && (diff >= -$signed({2'b00, speed.window[SPEED_W-2:0]})); // see R01
    near_zero = (speed.actual <= $signed(STOP_BAND)) && (speed.actual >= -$signed(STOP_BAND));
  end

  // Delay qualifier; a zero delay sets the flag on the first in-window sample
  always_comb begin
    next_delay_count = delay_count;
    next_speed_ok    = speed_ok;
    if (!in_window) begin
      next_delay_count = '0; // see R03
      next_speed_ok    = 1'b0; // see R03
    end else if (delay_count >= speed.delay_cycles) begin
      next_speed_ok    = 1'b1; // see R02
    end else begin
      next_delay_count = delay_count + 1'b1; // see R02
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      delay_count <= '0;
      speed_ok    <= 1'b0;
    end else begin
      delay_count <= next_delay_count;
      speed_ok    <= next_speed_ok;
    end
  end

  always_comb begin
    next_status = STATUS_RESET; // see R21
    unique case (drive_state)
      ST_INHIBITED: next_status[BIT_ON_INHIBIT] = 1'b1; // see R16
      ST_READY:     next_status[BIT_READY_ON]   = 1'b1; // see R16
      ST_SWITCHED: begin
        next_status[BIT_READY_ON] = 1'b1; // see R17
        next_status[BIT_READY_OP] = 1'b1; // see R17
      end
      ST_OPERATION: begin
        next_status[BIT_READY_ON] = 1'b1;
        next_status[BIT_READY_OP] = 1'b1;
      end
      ST_FAULT: begin
        next_status[BIT_FAULT]      = 1'b1;
        next_status[BIT_ON_INHIBIT] = 1'b1;
      end
      default: next_status[BIT_ON_INHIBIT] = 1'b1;
    endcase
    // Operation bit comes from enabling itself, so the state masks stay as coded
    next_status[BIT_OP_ENABLED] = controller_enabled; // see R05
    next_status[BIT_NO_COAST]   = !coast_stop_request; // see R06
    next_status[BIT_NO_QUICK]   = !quick_stop_request; // see R07
    next_status[BIT_WARNING]    = warning_active || limit_inhibit; // see R08
    next_status[BIT_PLC_CTRL]   = control_word[CTRL_PLC_BIT]; // see R10
    if (positioning_mode) begin // see R15
      next_status[BIT_WIN_FOLLOW] = !pos.following_error; // see R09
      next_status[BIT_REACHED]    = pos.run_finished && pos.in_target_window; // see R11
      next_status[BIT_HOME_VALID] = pos.absolute_encoder
                                 || (pos.homing_done && !pos.position_invalid); // see R12 R13
      next_status[BIT_TASK_ACK]   = pos.task_ack;
      next_status[BIT_STOPPED]    = near_zero && !pos.positioning_active
                                 && !quick_stop_request; // see R14
    end else begin
      next_status[BIT_WIN_FOLLOW] = speed_ok && in_window; // see R02 R03
      next_status[BIT_REACHED]    = speed.actual >= speed.threshold; // see R04
    end
  end

  // Registered word, held at a fixed position by the telegram builder
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      drive_status_word <= STATUS_RESET;
    end else begin
      drive_status_word <= next_status; // see R19
    end
  end

  sequence leave_window_s;
    !in_window;
  endsequence

  // Window entered with a zero delay, one sample after being outside it
  sequence enter_window_s;
    !in_window ##1 (in_window && speed.delay_cycles == '0);
  endsequence

  sequence held_speed_mode_s;
    in_window && !positioning_mode;
  endsequence

  leave_clears_a: assert property (@(posedge clk) disable iff (!rstn) // see R03
    (leave_window_s and !positioning_mode) |=> !drive_status_word[BIT_WIN_FOLLOW])
    else $error("speed bit 8 not cleared after leaving window");

  delay_gate_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
    (!positioning_mode && $rose(speed_ok)) |-> $past(delay_count >= speed.delay_cycles))
    else $error("speed bit 8 qualified early");

  threshold_a: assert property (@(posedge clk) disable iff (!rstn) // see R04
    !positioning_mode |=> drive_status_word[BIT_REACHED]
      == $past(speed.actual >= speed.threshold))
    else $error("threshold bit wrong");

  coast_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R06
    coast_stop_request |=> !drive_status_word[BIT_NO_COAST])
    else $error("coast stop bit not low");

  quick_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R07
    quick_stop_request |=> !drive_status_word[BIT_NO_QUICK])
    else $error("quick stop bit not low");

  plc_mirror_a: assert property (@(posedge clk) disable iff (!rstn) // see R10
    ##1 drive_status_word[BIT_PLC_CTRL] == $past(control_word[CTRL_PLC_BIT]))
    else $error("control bit not mirrored");

  home_abs_a: assert property (@(posedge clk) disable iff (!rstn) // see R13
    (positioning_mode && pos.absolute_encoder) |=> drive_status_word[BIT_HOME_VALID])
    else $error("home valid missing with absolute encoder");

  inhibit_code_a: assert property (@(posedge clk) disable iff (!rstn) // see R16
    (drive_state == ST_INHIBITED && !controller_enabled)
      |=> (drive_status_word & STATE_MASK) == VAL_INHIBITED)
    else $error("inhibited code wrong");

  switched_code_a: assert property (@(posedge clk) disable iff (!rstn) // see R17
    (drive_state == ST_SWITCHED && !controller_enabled)
      |=> (drive_status_word & STATE_MASK) == VAL_SWITCHED_ON)
    else $error("switched on code wrong");

  free_bits_a: assert property (@(posedge clk) disable iff (!rstn) // see R21
    drive_status_word[15:14] == 2'b00)
    else $error("free bits not zero");

  zero_delay_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
    (enter_window_s ##1 held_speed_mode_s) |=> drive_status_word[BIT_WIN_FOLLOW])
    else $error("speed bit 8 missing after zero delay");

  speed_gate_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
    (!positioning_mode && !speed_ok) |=> !drive_status_word[BIT_WIN_FOLLOW])
    else $error("speed bit 8 set before qualification");

  count_step_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
    (in_window && delay_count < speed.delay_cycles)
      |=> delay_count == $past(delay_count) + 1'b1)
    else $error("delay count did not advance");

  ok_hold_a: assert property (@(posedge clk) disable iff (!rstn) // see R02
    (speed_ok && in_window) |=> speed_ok)
    else $error("qualified flag dropped inside window");

  count_reset_a: assert property (@(posedge clk) disable iff (!rstn) // see R03
    !in_window |=> (delay_count == '0) && !speed_ok)
    else $error("delay count not restarted");

  window_centre_a: assert property (@(posedge clk) disable iff (!rstn) // see R01
    (speed.actual == speed.compare) |-> in_window)
    else $error("centre speed not in window");

  window_zero_a: assert property (@(posedge clk) disable iff (!rstn) // see R01
    (speed.window[SPEED_W-2:0] == '0 && speed.actual != speed.compare) |-> !in_window)
    else $error("zero width window accepted offset");

  threshold_low_a: assert property (@(posedge clk) disable iff (!rstn) // see R04
    (!positioning_mode && speed.actual < speed.threshold) |=> !drive_status_word[BIT_REACHED])
    else $error("threshold bit set below threshold");

  enable_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R05
    controller_enabled |=> drive_status_word[BIT_OP_ENABLED])
    else $error("enable bit not set");

  enable_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R05
    !controller_enabled |=> !drive_status_word[BIT_OP_ENABLED])
    else $error("enable bit not cleared");

  coast_idle_a: assert property (@(posedge clk) disable iff (!rstn) // see R06
    !coast_stop_request |=> drive_status_word[BIT_NO_COAST])
    else $error("coast bit low without request");

  quick_idle_a: assert property (@(posedge clk) disable iff (!rstn) // see R07
    !quick_stop_request |=> drive_status_word[BIT_NO_QUICK])
    else $error("quick bit low without request");

  warning_set_a: assert property (@(posedge clk) disable iff (!rstn) // see R08
    (warning_active || limit_inhibit) |=> drive_status_word[BIT_WARNING])
    else $error("warning bit not set");

  warning_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R08
    !(warning_active || limit_inhibit) |=> !drive_status_word[BIT_WARNING])
    else $error("warning bit not cleared");

  follow_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R09
    positioning_mode |=> drive_status_word[BIT_WIN_FOLLOW] == $past(!pos.following_error))
    else $error("following error bit wrong");

  target_bit_a: assert property (@(posedge clk) disable iff (!rstn) // see R11
    positioning_mode |=> drive_status_word[BIT_REACHED]
      == $past(pos.run_finished && pos.in_target_window))
    else $error("target reached bit wrong");

  home_set_a: assert property (@(posedge clk) disable iff (!rstn) // see R12
    (positioning_mode && pos.homing_done && !pos.position_invalid)
      |=> drive_status_word[BIT_HOME_VALID])
    else $error("home valid missing after homing");

  home_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R12
    (positioning_mode && !pos.absolute_encoder && (!pos.homing_done || pos.position_invalid))
      |=> !drive_status_word[BIT_HOME_VALID])
    else $error("home valid set without homing");

  stopped_set_a: assert property (@(posedge clk) disable iff (!rstn) // see R14
    (positioning_mode && near_zero && !pos.positioning_active && !quick_stop_request)
      |=> drive_status_word[BIT_STOPPED])
    else $error("stopped bit missing");

  stopped_clear_a: assert property (@(posedge clk) disable iff (!rstn) // see R14
    (positioning_mode && (pos.positioning_active || quick_stop_request))
      |=> !drive_status_word[BIT_STOPPED])
    else $error("stopped bit set while moving");

  speed_free_a: assert property (@(posedge clk) disable iff (!rstn) // see R15
    !positioning_mode |=> drive_status_word[BIT_STOPPED:BIT_HOME_VALID] == 3'b000)
    else $error("positioning bits set in speed mode");

  task_ack_a: assert property (@(posedge clk) disable iff (!rstn) // see R15
    positioning_mode |=> drive_status_word[BIT_TASK_ACK] == $past(pos.task_ack))
    else $error("task acknowledge bit wrong");

  ready_code_a: assert property (@(posedge clk) disable iff (!rstn) // see R16
    (drive_state == ST_READY && !controller_enabled)
      |=> (drive_status_word & STATE_MASK) == VAL_READY)
    else $error("ready code wrong");

  // A fault leaves the drive decodable as inhibited
  fault_code_a: assert property (@(posedge clk) disable iff (!rstn) // see R16
    (drive_state == ST_FAULT && !controller_enabled)
      |=> (drive_status_word & STATE_MASK) == VAL_INHIBITED)
    else $error("fault code wrong");

endmodule // drive_status_word_generator

// >>> verilog/status_word_pkg.sv
// Package: status word bit positions, state codes and timing constants
package status_word_pkg;

  // Status word bit positions
  localparam int unsigned BIT_READY_ON    = 0;
  localparam int unsigned BIT_READY_OP    = 1;
  localparam int unsigned BIT_OP_ENABLED  = 2;
  localparam int unsigned BIT_FAULT       = 3;
  localparam int unsigned BIT_NO_COAST    = 4;
  localparam int unsigned BIT_NO_QUICK    = 5;
  localparam int unsigned BIT_ON_INHIBIT  = 6;
  localparam int unsigned BIT_WARNING     = 7;
  localparam int unsigned BIT_WIN_FOLLOW  = 8;
  localparam int unsigned BIT_PLC_CTRL    = 9;
  localparam int unsigned BIT_REACHED     = 10;
  localparam int unsigned BIT_HOME_VALID  = 11;
  localparam int unsigned BIT_TASK_ACK    = 12;
  localparam int unsigned BIT_STOPPED     = 13;
  localparam int unsigned CTRL_PLC_BIT    = 10;

  localparam logic [15:0] STATE_MASK      = 16'h0047;
  localparam logic [15:0] VAL_INHIBITED   = 16'h0040;
  localparam logic [15:0] VAL_READY       = 16'h0001;
  localparam logic [15:0] VAL_SWITCHED_ON = 16'h0003;
  localparam logic [15:0] STATUS_RESET    = 16'h0000;

  localparam int unsigned SPEED_W = 32;
  localparam int unsigned DELAY_W = 24;
  localparam int unsigned CLK_MHZ = 200;
  // Default band around zero for the stopped flag, in speed units
  localparam logic [SPEED_W-1:0] STOP_BAND_DEF = 32'h0000_0010;

  // Drive state codes, one-hot
  typedef enum logic [4:0] {
    ST_INHIBITED  = 5'b00001,
    ST_READY      = 5'b00010,
    ST_SWITCHED   = 5'b00100,
    ST_OPERATION  = 5'b01000,
    ST_FAULT      = 5'b10000
  } drive_state_t;

  typedef struct packed {
    logic signed [SPEED_W-1:0] actual;
    logic signed [SPEED_W-1:0] compare;
    logic        [SPEED_W-1:0] window;
    logic signed [SPEED_W-1:0] threshold;
    logic        [DELAY_W-1:0] delay_cycles;
  } speed_cfg_t;

  typedef struct packed {
    logic following_error;
    logic run_finished;
    logic in_target_window;
    logic homing_done;
    logic position_invalid;
    logic absolute_encoder;
    logic positioning_active;
    logic task_ack;
  } pos_flags_t;

endpackage

// >>> test/plc_master_model.sv
// Partner: fieldbus master that sets the control word and decodes state
`timescale 1ns/10ps

module plc_master_model
  import status_word_pkg::*;
(
  input  wire logic                          plc_ctrl,
  input  wire logic [15:0]                   drive_status_word,
  output logic [15:0]                        control_word,
  output status_word_pkg::drive_state_t      decoded_state
);
  // Only bit 10 reaches the word; command bits stay idle here
  assign control_word = {5'h00, plc_ctrl, 10'h000};

  // Bits 4 and 5 follow the command, so the mask drops them
  always_comb begin
    case (drive_status_word & STATE_MASK)
      VAL_INHIBITED:   decoded_state = ST_INHIBITED;
      VAL_READY:       decoded_state = ST_READY;
      VAL_SWITCHED_ON: decoded_state = ST_SWITCHED;
      default:         decoded_state = ST_FAULT;
    endcase
  end
endmodule // plc_master_model

// >>> test/drive_status_word_generator_test.sv
// Bench: random and directed checks of the drive status word
`timescale 1ns/10ps

module drive_status_word_generator_test;
  import status_word_pkg::*;
  logic         clk = 0, rstn = 0, pmode = 0, ena = 0, coast = 0;
  logic         quick = 0, warn = 0, lim = 0, plc = 0, chk;
  speed_cfg_t   speed = '0;
  pos_flags_t   pos = '0;
  drive_state_t st = ST_INHIBITED, dec, est;
  logic [15:0]  cw, sw, e, m;
  int           miscompares = 0, checks_done = 0, k;
  drive_state_t tab [5] = '{ST_INHIBITED, ST_READY, ST_SWITCHED, ST_OPERATION, ST_FAULT};

  always #2.5 clk = ~clk;

  drive_status_word_generator drive_status_word_generator_inst (.clk(clk), .rstn(rstn),
    .speed(speed), .pos(pos), .drive_state(st), .positioning_mode(pmode), .control_word(cw),
    .controller_enabled(ena), .coast_stop_request(coast), .quick_stop_request(quick),
    .warning_active(warn), .limit_inhibit(lim), .drive_status_word(sw));
  plc_master_model plc_master_model_inst (.plc_ctrl(plc), .drive_status_word(sw),
    .control_word(cw), .decoded_state(dec));

  task automatic check(string n, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  function automatic logic [15:0] exp_word();
    logic [15:0] w;
    logic signed [31:0] a;
    w = 16'h0000;
    a = speed.actual;
    case (st)
      ST_INHIBITED: w[6] = 1'b1;
      ST_READY: w[0] = 1'b1;
      ST_SWITCHED, ST_OPERATION: w[1:0] = 2'b11;
      default: w[6:3] = 4'h9;
    endcase
    w[2] = ena;
    w[4] = !coast;
    w[5] = !quick;
    w[7] = warn | lim;
    w[9] = plc;
    if (pmode) begin
      w[8] = !pos.following_error;
      w[10] = pos.run_finished & pos.in_target_window;
      w[11] = pos.absolute_encoder | (pos.homing_done & !pos.position_invalid);
      w[12] = pos.task_ack;
      w[13] = a <= $signed(STOP_BAND_DEF) && a >= -$signed(STOP_BAND_DEF)
              && !pos.positioning_active && !quick;
    end else begin
      w[10] = a >= speed.threshold;
    end
    return w;
  endfunction

  task automatic step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Budget is about 2100 cycles; leave ample margin
  initial begin
    #50000;
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(33));
    repeat (4) @(posedge clk);
    check("reset word", sw, STATUS_RESET);
    rstn <= 1'b1;
    repeat (2000) begin
      @(posedge clk);
      e = exp_word();
      // Speed mode bit 8 depends on history; directed test covers it
      m = pmode ? 16'hffff : 16'hfeff;
      est = st;
      chk = !ena && st inside {ST_INHIBITED, ST_READY, ST_SWITCHED};
      speed.actual <= int'($urandom_range(80)) - 40;
      speed.compare <= int'($urandom_range(40)) - 20;
      speed.window <= $urandom_range(20);
      speed.threshold <= int'($urandom_range(80)) - 40;
      speed.delay_cycles <= 24'($urandom_range(7));
      pos <= 8'($urandom_range(255));
      st <= tab[$urandom_range(4)];
      {pmode, ena, coast, quick, warn, lim, plc} <= 7'($urandom());
      #1;
      check("status word", sw & m, e & m);
      if (chk) check("decoded state", {11'h000, dec}, {11'h000, est});
    end
    foreach (tab[j]) if (j < 3) begin
      @(posedge clk);
      st <= tab[j];
      ena <= 1'b0;
      k = 0;
      do begin step(1); k++; end while (dec !== tab[j] && k < 8);
      check("state reached", {11'h000, dec}, {11'h000, tab[j]});
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      pmode <= 1'b0;
      speed <= '{actual: 0, compare: 100, window: 10, threshold: 0,
                 delay_cycles: 24'h000005};
      @(posedge clk);
      speed.actual <= (i == 0) ? 110 : 90;
      step(6);
      check("window early", {15'h0, sw[8]}, 16'h0000);
      step(2);
      check("window held", {15'h0, sw[8]}, 16'h0001);
      @(posedge clk);
      speed.actual <= (i == 0) ? 111 : 89;
      @(posedge clk);
      speed.actual <= (i == 0) ? 110 : 90;
      #1;
      check("window left", {15'h0, sw[8]}, 16'h0000);
      step(5);
      check("delay restart", {15'h0, sw[8]}, 16'h0000);
      step(3);
      check("window again", {15'h0, sw[8]}, 16'h0001);
    end
    end_sim();
  end
endmodule // drive_status_word_generator_test
